// file: pprx_expander.sv
// parallel poll relay and direction control of a two-bus instrument expander
`include "pprx_defs.svh"
module pprx_expander
  import pprx_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // bus a inputs, true = asserted
  input wire logic [7:0] a_dio_i,
  input wire logic a_atn_i,
  input wire logic a_eoi_i,
  input wire logic a_dav_i,
  input wire logic a_ifc_i,
  input wire logic a_ren_i,
  // bus a drivers, enable low while driving
  output logic [7:0] a_dio_o,
  output logic a_dio_oe_n,
  output logic a_atn_o,
  output logic a_atn_oe_n,
  output logic a_eoi_o,
  output logic a_eoi_oe_n,
  // bus b inputs, true = asserted
  input wire logic [7:0] b_dio_i,
  input wire logic b_atn_i,
  input wire logic b_eoi_i,
  input wire logic b_dav_i,
  input wire logic b_ifc_i,
  input wire logic b_ren_i,
  // bus b drivers, enable low while driving
  output logic [7:0] b_dio_o,
  output logic b_dio_oe_n,
  output logic b_atn_o,
  output logic b_atn_oe_n,
  output logic b_eoi_o,
  output logic b_eoi_oe_n,
  // tracking state
  output logic a_sys_ctrl,
  output logic b_sys_ctrl,
  output logic a_act_ctrl,
  output logic b_act_ctrl,
  output logic a_src_hs,
  output logic b_src_hs
);
  localparam int SW = `PPRX_SYNC_W;
  localparam int GW = `PPRX_OWN_GUARD;

  pprx_relay_if rif_a ();
  pprx_relay_if rif_b ();

  logic [1:0][SW-1:0] s1_r, s2_r, s3_r, flt_r;
  logic [1:0][SW-1:0] s1_nxt, s2_nxt, s3_nxt, flt_nxt;
  logic [GW-1:0] own_a_r, own_b_r, own_a_nxt, own_b_nxt;
  logic guard_a, guard_b, poll_a, poll_b;
  pprx_dio_t dio_a, dio_b;
  logic sc_a_r, sc_b_r, ac_a_r, ac_b_r, sh_a_r, sh_b_r;
  logic sc_a_nxt, sc_b_nxt, ac_a_nxt, ac_b_nxt, sh_a_nxt, sh_b_nxt;
  pprx_dio_t a_dio_r, b_dio_r, a_dio_nxt, b_dio_nxt;
  logic a_dio_oe_n_r, b_dio_oe_n_r, a_dio_oe_n_nxt, b_dio_oe_n_nxt;
  logic a_pp_r, b_pp_r, a_pp_nxt, b_pp_nxt;
  logic a_idy_oe_n_r, b_idy_oe_n_r, a_idy_oe_n_nxt, b_idy_oe_n_nxt;
  logic a_norm_ok, b_norm_ok;

  // input synchronisers: a bit changes once the second and third stage agree
  always_comb begin
    s1_nxt[0] = {a_dio_i, a_atn_i, a_eoi_i, a_dav_i, a_ifc_i, a_ren_i};
    s1_nxt[1] = {b_dio_i, b_atn_i, b_eoi_i, b_dav_i, b_ifc_i, b_ren_i};
    s2_nxt = s1_r;
    s3_nxt = s2_r;
    for (int i = 0; i < 2; i++) begin
      flt_nxt[i] = (~(s2_r[i] ^ s3_r[i]) & s2_r[i]) | ((s2_r[i] ^ s3_r[i]) & flt_r[i]);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      flt_r <= '0;
    end else begin
      s1_r <= s1_nxt;
      s2_r <= s2_nxt;
      s3_r <= s3_nxt;
      flt_r <= flt_nxt;
    end
  end

  assign dio_a = flt_r[0][SW-1:`PPRX_F_DIO_LSB];
  assign dio_b = flt_r[1][SW-1:`PPRX_F_DIO_LSB];
  // our own relayed identify echoes back through the synchroniser; mask it
  assign guard_a = a_pp_r | (|own_a_r);
  assign guard_b = b_pp_r | (|own_b_r);
  assign poll_a = flt_r[0][`PPRX_F_ATN] & flt_r[0][`PPRX_F_EOI] & !guard_a;
  assign poll_b = flt_r[1][`PPRX_F_ATN] & flt_r[1][`PPRX_F_EOI] & !guard_b;

  assign rif_a.pri_poll = poll_a;
  assign rif_a.sec_dio = dio_b;
  assign rif_b.pri_poll = poll_b;
  assign rif_b.sec_dio = dio_a;

  pprx_relay u_relay_a (
    .sys_clk(sys_clk),
    .srst(srst),
    .rif(rif_a)
  );

  pprx_relay u_relay_b (
    .sys_clk(sys_clk),
    .srst(srst),
    .rif(rif_b)
  );

  // controller and source tracking; bus a wins a same-cycle tie
  always_comb begin
    own_a_nxt = {own_a_r[GW-2:0], a_pp_r};
    own_b_nxt = {own_b_r[GW-2:0], b_pp_r};
    sc_a_nxt = sc_a_r;
    sc_b_nxt = sc_b_r;
    ac_a_nxt = ac_a_r;
    ac_b_nxt = ac_b_r;
    sh_a_nxt = sh_a_r;
    sh_b_nxt = sh_b_r;
    if (flt_r[0][`PPRX_F_IFC] | flt_r[0][`PPRX_F_REN]) begin
      sc_a_nxt = 1'b1;
      sc_b_nxt = 1'b0;
    end else if (flt_r[1][`PPRX_F_IFC] | flt_r[1][`PPRX_F_REN]) begin
      sc_a_nxt = 1'b0;
      sc_b_nxt = 1'b1;
    end
    if (flt_r[0][`PPRX_F_ATN] & !guard_a) begin
      ac_a_nxt = 1'b1;
      ac_b_nxt = 1'b0;
    end else if (flt_r[1][`PPRX_F_ATN] & !guard_b) begin
      ac_a_nxt = 1'b0;
      ac_b_nxt = 1'b1;
    end
    if (flt_r[0][`PPRX_F_DAV]) begin
      sh_a_nxt = 1'b1;
      sh_b_nxt = 1'b0;
    end else if (flt_r[1][`PPRX_F_DAV]) begin
      sh_a_nxt = 1'b0;
      sh_b_nxt = 1'b1;
    end
  end

  // data direction: a running poll overrides the source handshake choice
  always_comb begin
    a_norm_ok = !(poll_a | poll_b | rif_b.sec_poll_drv);
    b_norm_ok = !(poll_b | poll_a | rif_a.sec_poll_drv);
    a_pp_nxt = rif_b.sec_poll_drv;
    b_pp_nxt = rif_a.sec_poll_drv;
    // enables kept in their own flops so the pins see no inverter
    a_idy_oe_n_nxt = !rif_b.sec_poll_drv;
    b_idy_oe_n_nxt = !rif_a.sec_poll_drv;
    a_dio_nxt = 8'h00;
    a_dio_oe_n_nxt = 1'b1;
    b_dio_nxt = 8'h00;
    b_dio_oe_n_nxt = 1'b1;
    if (rif_a.pri_vld) begin
      a_dio_nxt = rif_a.pri_dio;
      a_dio_oe_n_nxt = 1'b0;
    end else if (sh_b_r && a_norm_ok) begin
      a_dio_nxt = dio_b;
      a_dio_oe_n_nxt = 1'b0;
    end
    if (rif_b.pri_vld) begin
      b_dio_nxt = rif_b.pri_dio;
      b_dio_oe_n_nxt = 1'b0;
    end else if (sh_a_r && b_norm_ok) begin
      b_dio_nxt = dio_a;
      b_dio_oe_n_nxt = 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      own_a_r <= '0;
      own_b_r <= '0;
      sc_a_r <= 1'b0;
      sc_b_r <= 1'b0;
      ac_a_r <= 1'b0;
      ac_b_r <= 1'b0;
      sh_a_r <= 1'b0;
      sh_b_r <= 1'b0;
      a_pp_r <= 1'b0;
      b_pp_r <= 1'b0;
      a_idy_oe_n_r <= 1'b1;
      b_idy_oe_n_r <= 1'b1;
      a_dio_r <= 8'h00;
      b_dio_r <= 8'h00;
      a_dio_oe_n_r <= 1'b1;
      b_dio_oe_n_r <= 1'b1;
    end else begin
      own_a_r <= own_a_nxt;
      own_b_r <= own_b_nxt;
      sc_a_r <= sc_a_nxt;
      sc_b_r <= sc_b_nxt;
      ac_a_r <= ac_a_nxt;
      ac_b_r <= ac_b_nxt;
      sh_a_r <= sh_a_nxt;
      sh_b_r <= sh_b_nxt;
      a_pp_r <= a_pp_nxt;
      b_pp_r <= b_pp_nxt;
      a_idy_oe_n_r <= a_idy_oe_n_nxt;
      b_idy_oe_n_r <= b_idy_oe_n_nxt;
      a_dio_r <= a_dio_nxt;
      b_dio_r <= b_dio_nxt;
      a_dio_oe_n_r <= a_dio_oe_n_nxt;
      b_dio_oe_n_r <= b_dio_oe_n_nxt;
    end
  end

  assign a_dio_o = a_dio_r;
  assign a_dio_oe_n = a_dio_oe_n_r;
  assign a_atn_o = a_pp_r;
  assign a_atn_oe_n = a_idy_oe_n_r;
  assign a_eoi_o = a_pp_r;
  assign a_eoi_oe_n = a_idy_oe_n_r;
  assign b_dio_o = b_dio_r;
  assign b_dio_oe_n = b_dio_oe_n_r;
  assign b_atn_o = b_pp_r;
  assign b_atn_oe_n = b_idy_oe_n_r;
  assign b_eoi_o = b_pp_r;
  assign b_eoi_oe_n = b_idy_oe_n_r;
  assign a_sys_ctrl = sc_a_r;
  assign b_sys_ctrl = sc_b_r;
  assign a_act_ctrl = ac_a_r;
  assign b_act_ctrl = ac_b_r;
  assign a_src_hs = sh_a_r;
  assign b_src_hs = sh_b_r;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  a_reset_clear: assert property ($past(srst) |-> (!sc_a_r && !ac_b_r && !sh_a_r && a_dio_oe_n
    && b_dio_oe_n && a_atn_oe_n && b_atn_oe_n))
    else $error("state not cleared by reset");
  a_poll_a_result: assert property (rif_a.pri_vld |=> (!a_dio_oe_n && a_dio_o == $past(rif_a.pri_dio)))
    else $error("bus a poll result not driven");
  a_poll_b_result: assert property (rif_b.pri_vld |=> (!b_dio_oe_n && b_dio_o == $past(rif_b.pri_dio)))
    else $error("bus b poll result not driven");
  a_relay_pins: assert property (rif_a.sec_poll_drv |=> (b_atn_o && b_eoi_o && !b_eoi_oe_n))
    else $error("identify not driven on bus b");
  a_poll_override: assert property ((poll_b && !rif_b.pri_vld) |=> b_dio_oe_n)
    else $error("data driven onto a bus under poll");
  a_normal_dir: assert property ((sh_b_r && a_norm_ok && !rif_a.pri_vld) |=>
    (!a_dio_oe_n && a_dio_o == $past(dio_b)))
    else $error("normal data direction wrong");
  a_src_single: assert property (!(sh_a_r && sh_b_r) && !(ac_a_r && ac_b_r))
    else $error("tracking state true on both buses");
endmodule // pprx_expander

// file: pprx_defs.svh
// constants of the parallel poll relay expander
`ifndef PPRX_DEFS_SVH
`define PPRX_DEFS_SVH
`define PPRX_CLK_PERIOD_NS 40
`define PPRX_MSG_DELAY_NS 400
`define PPRX_MSG_DELAY_CYC ((`PPRX_MSG_DELAY_NS) / (`PPRX_CLK_PERIOD_NS))
`define PPRX_SAMPLE_NS 600
`define PPRX_SAMPLE_CYC ((`PPRX_SAMPLE_NS + `PPRX_CLK_PERIOD_NS - 1) / `PPRX_CLK_PERIOD_NS)
`define PPRX_SAMPLE_CNT_W 5
`define PPRX_DIO_W 8
`define PPRX_SYNC_W 13
`define PPRX_OWN_GUARD 4
`define PPRX_F_REN 0
`define PPRX_F_IFC 1
`define PPRX_F_DAV 2
`define PPRX_F_EOI 3
`define PPRX_F_ATN 4
`define PPRX_F_DIO_LSB 5
`endif

// file: pprx_pkg.sv
// types of the parallel poll relay expander
package pprx_pkg;
  typedef enum logic [2:0] {
    PPRX_IDLE = 3'h1,
    PPRX_RUN = 3'h2,
    PPRX_TAIL = 3'h4
  } pprx_state_e;
  typedef logic [7:0] pprx_dio_t;
endpackage

// file: pprx_relay_if.sv
// link between the top and one poll relay direction
interface pprx_relay_if;
  import pprx_pkg::*;
  logic pri_poll;
  pprx_dio_t sec_dio;
  logic sec_poll_drv;
  pprx_dio_t pri_dio;
  logic pri_vld;
  pprx_dio_t fin_dio;
  logic fin_stb;
  modport relay (input pri_poll, input sec_dio, output sec_poll_drv, output pri_dio,
    output pri_vld, output fin_dio, output fin_stb);
  modport ctrl (output pri_poll, output sec_dio, input sec_poll_drv, input pri_dio,
    input pri_vld, input fin_dio, input fin_stb);
endinterface

// file: pprx_relay.sv
// one direction of the parallel poll relay: primary poll to secondary bus and back
`include "pprx_defs.svh"
module pprx_relay
  import pprx_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // link to the top
  pprx_relay_if.relay rif
);
  localparam int DLY = `PPRX_MSG_DELAY_CYC;
  localparam int PER = `PPRX_SAMPLE_CYC;
  localparam logic [`PPRX_SAMPLE_CNT_W-1:0] PER_LAST = `PPRX_SAMPLE_CNT_W'(PER - 1);

  logic [DLY-1:0] dly_r, dly_nxt;
  pprx_state_e state_r, state_nxt;
  logic [`PPRX_SAMPLE_CNT_W-1:0] cnt_r, cnt_nxt;
  pprx_dio_t pri_dio_r, pri_dio_nxt, fin_dio_r, fin_dio_nxt;
  logic pri_vld_r, pri_vld_nxt, fin_stb_r, fin_stb_nxt;
  logic sample_now, final_evt;

  always_comb begin
    // a delay line moves both poll edges by the same time, so length is kept
    dly_nxt = {dly_r[DLY-2:0], rif.pri_poll};
    sample_now = (state_r == PPRX_RUN) && rif.pri_poll && (cnt_r == PER_LAST);
    final_evt = dly_r[DLY-1] && !dly_r[DLY-2];
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    pri_dio_nxt = pri_dio_r;
    pri_vld_nxt = pri_vld_r;
    fin_stb_nxt = final_evt;
    fin_dio_nxt = final_evt ? rif.sec_dio : fin_dio_r;
    case (state_r)
      PPRX_IDLE: begin
        if (rif.pri_poll) begin
          state_nxt = PPRX_RUN;
          cnt_nxt = '0;
          pri_vld_nxt = 1'b0;
        end
      end
      PPRX_RUN: begin
        if (!rif.pri_poll) begin
          state_nxt = PPRX_TAIL;
          pri_vld_nxt = 1'b0;
        end else if (sample_now) begin
          pri_dio_nxt = rif.sec_dio;
          pri_vld_nxt = 1'b1;
          cnt_nxt = '0;
        end else begin
          cnt_nxt = cnt_r + 1'b1;
        end
      end
      PPRX_TAIL: begin
        // a new poll is only seen once the old secondary poll has ended
        if (final_evt) begin
          state_nxt = PPRX_IDLE;
        end
      end
      default: begin
        state_nxt = PPRX_IDLE;
        pri_vld_nxt = 1'b0;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      dly_r <= '0;
      state_r <= PPRX_IDLE;
      cnt_r <= '0;
      pri_dio_r <= 8'h00;
      pri_vld_r <= 1'b0;
      fin_dio_r <= 8'h00;
      fin_stb_r <= 1'b0;
    end else begin
      dly_r <= dly_nxt;
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      pri_dio_r <= pri_dio_nxt;
      pri_vld_r <= pri_vld_nxt;
      fin_dio_r <= fin_dio_nxt;
      fin_stb_r <= fin_stb_nxt;
    end
  end

  assign rif.sec_poll_drv = dly_r[DLY-1];
  assign rif.pri_dio = pri_dio_r;
  assign rif.pri_vld = pri_vld_r;
  assign rif.fin_dio = fin_dio_r;
  assign rif.fin_stb = fin_stb_r;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  a_start_delay: assert property ($rose(rif.pri_poll) |-> ##[DLY:DLY] $rose(rif.sec_poll_drv))
    else $error("secondary poll did not start after the message delay");
  a_end_delay: assert property ($fell(rif.pri_poll) |-> ##[DLY:DLY] $fell(rif.sec_poll_drv))
    else $error("secondary poll did not end after the message delay");
  a_first_sample: assert property ((state_r == PPRX_IDLE && rif.pri_poll) |=> (!rif.pri_vld)[*8])
    else $error("sample forwarded too early");
  a_sample_take: assert property (sample_now |=> (rif.pri_vld && rif.pri_dio == $past(rif.sec_dio)))
    else $error("periodic sample not forwarded");
  a_sample_hold: assert property ((rif.pri_vld && rif.pri_poll && !sample_now) |=>
    (rif.pri_vld && $stable(rif.pri_dio)))
    else $error("forwarded sample not held");
  a_poll_release: assert property (!rif.pri_poll |=> !rif.pri_vld)
    else $error("sample still shown after poll end");
  a_final_capture: assert property (final_evt |=> (rif.fin_stb && rif.fin_dio == $past(rif.sec_dio)))
    else $error("final sample not captured");
  c_one_sample: cover property (sample_now);
  c_two_samples: cover property (sample_now ##[1:20] sample_now);
  c_final_resp: cover property (final_evt && rif.sec_dio != 8'h00);
endmodule // pprx_relay

// file: pprx_bus_model.sv
// instrument group on one bus answering parallel polls
module pprx_bus_model
  import pprx_pkg::*;
(
  // clock
  input wire logic sys_clk,
  // identify as seen on this bus
  input wire logic idy,
  // answer setup
  input wire pprx_dio_t resp,
  input wire logic [7:0] dly,
  // data lines pulled by the instruments
  output pprx_dio_t dio
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] cnt;
  initial cnt = 8'h00;
  always @(posedge sys_clk) begin
    if (!idy) cnt <= 8'h00;
    else if (cnt < dly) cnt <= cnt + 8'h01;
  end
  // released lines float back to false through the pull-ups
  assign dio = (idy && cnt >= dly) ? resp : 8'h00;
endmodule // pprx_bus_model

// file: pprx_expander_bench.sv
// self-checking bench of the parallel poll relay expander
module pprx_expander_bench;
  import pprx_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {logic s; pprx_dio_t r; logic [7:0] len;} pprx_row_s;
  logic sys_clk, srst, side;
  pprx_dio_t a_dio_d, b_dio_d, a_dio_o, b_dio_o, a_dio_i, b_dio_i, a_mdl, b_mdl, resp;
  logic [7:0] dly;
  logic a_atn_d, a_eoi_d, a_dav_d, a_ifc_d, a_ren_d, b_atn_d, b_eoi_d, b_dav_d, b_ifc_d, b_ren_d;
  logic a_dio_oe_n, a_atn_o, a_atn_oe_n, a_eoi_o, a_eoi_oe_n, a_atn_i, a_eoi_i;
  logic b_dio_oe_n, b_atn_o, b_atn_oe_n, b_eoi_o, b_eoi_oe_n, b_atn_i, b_eoi_i;
  logic a_sys_ctrl, b_sys_ctrl, a_act_ctrl, b_act_ctrl, a_src_hs, b_src_hs;
  int n_mismatch, num_checks;
  pprx_row_s rows [4] = '{'{1'b0, 8'hA5, 8'd55}, '{1'b1, 8'h3C, 8'd60},
    '{1'b0, 8'hFF, 8'd70}, '{1'b1, 8'h01, 8'd100}};
  // wired-or of every party on each line
  assign a_atn_i = a_atn_d | (a_atn_o & ~a_atn_oe_n);
  assign a_eoi_i = a_eoi_d | (a_eoi_o & ~a_eoi_oe_n);
  assign b_atn_i = b_atn_d | (b_atn_o & ~b_atn_oe_n);
  assign b_eoi_i = b_eoi_d | (b_eoi_o & ~b_eoi_oe_n);
  assign a_dio_i = a_dio_d | a_mdl | (a_dio_oe_n ? 8'h00 : a_dio_o);
  assign b_dio_i = b_dio_d | b_mdl | (b_dio_oe_n ? 8'h00 : b_dio_o);
  wire pri_oe_n = side ? b_dio_oe_n : a_dio_oe_n;
  wire pprx_dio_t pri_dio = side ? b_dio_o : a_dio_o;
  wire sec_idy_n = side ? a_atn_oe_n : b_atn_oe_n;
  pprx_bus_model mdl_a (.sys_clk(sys_clk), .idy(a_atn_i & a_eoi_i), .resp(resp), .dly(dly),
    .dio(a_mdl));
  pprx_bus_model mdl_b (.sys_clk(sys_clk), .idy(b_atn_i & b_eoi_i), .resp(resp), .dly(dly),
    .dio(b_mdl));
  pprx_expander dut (.sys_clk(sys_clk), .srst(srst), .a_dio_i(a_dio_i), .a_atn_i(a_atn_i),
    .a_eoi_i(a_eoi_i), .a_dav_i(a_dav_d), .a_ifc_i(a_ifc_d), .a_ren_i(a_ren_d),
    .a_dio_o(a_dio_o), .a_dio_oe_n(a_dio_oe_n), .a_atn_o(a_atn_o), .a_atn_oe_n(a_atn_oe_n),
    .a_eoi_o(a_eoi_o), .a_eoi_oe_n(a_eoi_oe_n), .b_dio_i(b_dio_i), .b_atn_i(b_atn_i),
    .b_eoi_i(b_eoi_i), .b_dav_i(b_dav_d), .b_ifc_i(b_ifc_d), .b_ren_i(b_ren_d),
    .b_dio_o(b_dio_o), .b_dio_oe_n(b_dio_oe_n), .b_atn_o(b_atn_o), .b_atn_oe_n(b_atn_oe_n),
    .b_eoi_o(b_eoi_o), .b_eoi_oe_n(b_eoi_oe_n), .a_sys_ctrl(a_sys_ctrl),
    .b_sys_ctrl(b_sys_ctrl), .a_act_ctrl(a_act_ctrl), .b_act_ctrl(b_act_ctrl),
    .a_src_hs(a_src_hs), .b_src_hs(b_src_hs));
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  task automatic chk1(input logic got, input logic exp, input string what);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: %s got %b expected %b", $time, what, got, exp);
    end
  endtask
  task automatic chk8(input pprx_dio_t got, input pprx_dio_t exp, input string what);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // sel 0 primary data enable, 1 relayed identify enable, 2 primary data equals answer
  task automatic wait_lvl(input int sel, input logic lvl, inout int t);
    int k;
    for (k = 0; k < 80; k++) begin
      if (sel == 2 ? (pri_dio === resp) : ((sel == 1 ? sec_idy_n : pri_oe_n) === lvl)) return;
      @(negedge sys_clk);
      t++;
    end
    n_mismatch++;
    $display("Error at %0t: wait ran out", $time);
    conclude();
  endtask
  task automatic run_poll(input logic s, input pprx_dio_t r, input logic [7:0] d,
    input pprx_dio_t e1, input int len);
    int t;
    t = 0;
    side = s;
    resp = r;
    dly = d;
    if (s) {b_atn_d, b_eoi_d} = 2'b11;
    else {a_atn_d, a_eoi_d} = 2'b11;
    wait_lvl(1, 1'b0, t);
    chk1(t >= 12 && t <= 16, 1'b1, "relay start");
    chk1(s ? (a_atn_o & a_eoi_o & ~a_eoi_oe_n) : (b_atn_o & b_eoi_o & ~b_eoi_oe_n), 1'b1,
      "relay identify pins");
    wait_lvl(0, 1'b0, t);
    chk1(t >= 18 && t <= 22, 1'b1, "first sample time");
    chk8(pri_dio, e1, "first sample");
    if (e1 !== r) begin
      // slow answer misses the first two samples and lands in the third
      wait_lvl(2, 1'b0, t);
      chk1(t >= 48 && t <= 52, 1'b1, "late sample time");
    end
    while (t < len) begin
      @(negedge sys_clk);
      t++;
    end
    chk8(pri_dio, r, "held sample");
    chk1(sec_idy_n, 1'b0, "relay still on");
    {a_atn_d, a_eoi_d, b_atn_d, b_eoi_d} = 4'h0;
    t = 0;
    wait_lvl(0, 1'b1, t);
    chk1(t >= 4 && t <= 6, 1'b1, "primary release");
    wait_lvl(1, 1'b1, t);
    chk1(t >= 12 && t <= 16, 1'b1, "relay end");
    chk1(s ? (a_atn_o | a_eoi_o | ~a_eoi_oe_n) : (b_atn_o | b_eoi_o | ~b_eoi_oe_n), 1'b0,
      "relay identify off");
    repeat (20) @(negedge sys_clk);
    $display("poll test done, side %0d", s);
  endtask
  initial begin
    srst = 1'b1;
    {a_atn_d, a_eoi_d, a_dav_d, a_ifc_d, a_ren_d} = 5'h00;
    {b_atn_d, b_eoi_d, b_dav_d, b_ifc_d, b_ren_d} = 5'h00;
    a_dio_d = 8'h00;
    b_dio_d = 8'h00;
    side = 1'b0;
    resp = 8'h00;
    dly = 8'h00;
    n_mismatch = 0;
    num_checks = 0;
    repeat (2) @(negedge sys_clk);
    srst = 1'b0;
    chk1(a_dio_oe_n & b_dio_oe_n & a_atn_oe_n & b_atn_oe_n, 1'b1, "idle drivers");
    chk1(a_sys_ctrl | b_sys_ctrl | a_act_ctrl | b_act_ctrl | a_src_hs | b_src_hs, 1'b0,
      "idle tracking");
    $display("reset test done");
    foreach (rows[i]) run_poll(rows[i].s, rows[i].r, 8'h00, rows[i].r, rows[i].len);
    chk1(b_act_ctrl & ~a_act_ctrl, 1'b1, "active controller b");
    run_poll(1'b0, 8'h96, 8'h14, 8'h00, 80);
    chk1(a_act_ctrl & ~b_act_ctrl, 1'b1, "active controller a");
    a_ifc_d = 1'b1;
    repeat (8) @(negedge sys_clk);
    chk1(a_sys_ctrl & ~b_sys_ctrl, 1'b1, "system controller a");
    a_ifc_d = 1'b0;
    b_ren_d = 1'b1;
    repeat (8) @(negedge sys_clk);
    chk1(b_sys_ctrl & ~a_sys_ctrl, 1'b1, "system controller b");
    a_dav_d = 1'b1;
    a_dio_d = 8'h5A;
    repeat (8) @(negedge sys_clk);
    chk1(a_src_hs & ~b_src_hs, 1'b1, "source a");
    chk8(b_dio_o, 8'h5A, "normal direction data");
    chk1(b_dio_oe_n, 1'b0, "normal direction enable");
    // source moves to bus b; old bytes on b die out within a few cycles
    a_dav_d = 1'b0;
    a_dio_d = 8'h00;
    b_dav_d = 1'b1;
    b_dio_d = 8'hC3;
    repeat (16) @(negedge sys_clk);
    chk1(b_src_hs & ~a_src_hs, 1'b1, "source b");
    chk8(a_dio_o, 8'hC3, "reverse direction data");
    chk1(a_dio_oe_n, 1'b0, "reverse direction enable");
    $display("tracking test done");
    // second reset in mid-run with a source still active
    srst = 1'b1;
    repeat (2) @(negedge sys_clk);
    srst = 1'b0;
    chk1(a_src_hs | b_src_hs | b_sys_ctrl, 1'b0, "tracking after reset");
    chk1(a_dio_oe_n & b_dio_oe_n, 1'b1, "driver after reset");
    $display("mid-run reset test done");
    conclude();
  end
endmodule // pprx_expander_bench
